/* File: core/tlbw_apb.sv */
// APB register slave of the transmit line buffer write port.
`timescale 1ns/100ps
module tlbw_apb
  import tlbw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  tlbw_regs_if.regs rif
);
  logic [CNT_W-1:0] fill_q;
  logic [PART_W-1:0] sel_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] status_w;
  logic [DATA_W-1:0] rd_d;

  wire hit_fill = paddr == OFS_FILL;
  wire hit_sel = paddr == OFS_SEL;
  wire hit_stat = paddr == OFS_STATUS;
  wire hit_pop = paddr == OFS_POP;
  wire hit_data = paddr >= OFS_DATA0 && paddr <= OFS_DATA3 &&
    paddr[DSEL_LSB-1:0] == '0;
  wire mapped = hit_fill | hit_sel | hit_stat | hit_pop | hit_data;
  wire wr_go = psel & penable & pwrite & mapped;
  wire [WSEL_W-1:0] dsel = paddr[DSEL_LSB +: WSEL_W];

  assign pready = penable;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = rdata_q;
  assign rif.fill_level = fill_q;
  assign rif.read_sel = sel_q;
  assign rif.pop = wr_go & hit_pop;

  always_comb
  begin
    status_w = '0;
    status_w[ST_DIS] = rif.service_off;
    status_w[ST_LEVEL +: CNT_W] = rif.level;
    status_w[ST_SOP] = rif.head_sop;
    status_w[ST_EOP] = rif.head_eop;
    status_w[ST_ERR] = rif.head_err;
    status_w[ST_BE +: BE_W] = rif.head_be;
    status_w[ST_PORT +: PORT_W] = rif.head_port;
  end

  assign rd_d = hit_fill ? DATA_W'(fill_q) :
    hit_sel ? DATA_W'(sel_q) :
    hit_stat ? status_w :
    hit_data ? rif.head_line[dsel] : '0;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fill_q <= FILL_RST;
      sel_q <= '0;
      rdata_q <= '0;
    end
    else
    begin
      if (wr_go && hit_fill)
      begin
        fill_q <= pwdata[CNT_W-1:0];
      end
      if (wr_go && hit_sel)
      begin
        sel_q <= pwdata[PART_W-1:0];
      end
      if (psel && !penable && !pwrite)
      begin
        rdata_q <= rd_d;
      end
    end
  end
endmodule : tlbw_apb

/* File: core/tlbw_pkg.sv */
// Shared constants and types of the transmit line buffer write port.
package tlbw_pkg;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int BYTE_W = 8;
  localparam int PART_N = 8;
  localparam int PART_W = 3;
  localparam int LINES_PER_PART = 4;
  localparam int LPTR_W = 2;
  localparam int CNT_W = 3;
  localparam int WORDS_PER_LINE = 4;
  localparam int WSEL_W = 2;
  localparam int PORT_W = 8;
  localparam int LINE_N = PART_N * LINES_PER_PART;
  localparam int WORD_N = LINE_N * WORDS_PER_LINE;
  localparam int LINE_IDX_W = PART_W + LPTR_W;
  localparam int WORD_IDX_W = LINE_IDX_W + WSEL_W;
  localparam int ADDR_W = 8;
  localparam int DSEL_LSB = 2;
  localparam logic [CNT_W-1:0] LINES_MAX = 3'h4;
  localparam logic [CNT_W-1:0] FILL_RST = 3'h4;
  localparam logic [WSEL_W-1:0] LAST_WORD = 2'h3;
  localparam logic [BE_W-1:0] BE_NONE = 4'h0;
  localparam logic [BE_W-1:0] BE_ALL = 4'hF;
  localparam logic [ADDR_W-1:0] OFS_FILL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SEL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_POP = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_DATA0 = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_DATA3 = 8'h1C;
  localparam int ST_DIS = 0;
  localparam int ST_LEVEL = 4;
  localparam int ST_SOP = 8;
  localparam int ST_EOP = 9;
  localparam int ST_ERR = 10;
  localparam int ST_BE = 12;
  localparam int ST_PORT = 16;

  typedef struct packed {
    logic wclk;
    logic [DATA_W-1:0] data;
    logic [BE_W-1:0] be;
    logic sop;
    logic eop;
    logic err;
    logic we;
    logic [PORT_W-1:0] port;
    logic [PART_W-1:0] part;
    logic term;
    logic dis;
  } tlbw_pins_t;
endpackage : tlbw_pkg

/* File: core/tlbw_regs_if.sv */
// Signals between the register slave and the buffer core.
`timescale 1ns/100ps
interface tlbw_regs_if
  import tlbw_pkg::*;
  ();
  logic [CNT_W-1:0] fill_level;
  logic [PART_W-1:0] read_sel;
  logic pop;
  logic service_off;
  logic [CNT_W-1:0] level;
  logic head_sop;
  logic head_eop;
  logic head_err;
  logic [BE_W-1:0] head_be;
  logic [PORT_W-1:0] head_port;
  logic [WORDS_PER_LINE-1:0][DATA_W-1:0] head_line;
  modport regs (output fill_level, read_sel, pop, input service_off, level,
    head_sop, head_eop, head_err, head_be, head_port, head_line);
  modport core (input fill_level, read_sel, pop, output service_off, level,
    head_sop, head_eop, head_err, head_be, head_port, head_line);
endinterface : tlbw_regs_if

/* File: core/tlbw_sync.sv */
// Two-stage synchroniser for a bundle of asynchronous inputs.
`timescale 1ns/100ps
module tlbw_sync #(
  parameter int W = 1
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] sync_q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end
endmodule : tlbw_sync

/* File: core/tlbw_top.sv */
// Write port of one transmit buffer memory split into partitions.
`timescale 1ns/100ps
module tlbw_top
  import tlbw_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [DATA_W-1:0] PWDATA,
  output logic [DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic WRITE_SIDE_CLOCK,
  input wire logic [DATA_W-1:0] WRITE_WORD_BUS,
  input wire logic [BE_W-1:0] BYTE_VALID_MASK,
  input wire logic PACKET_START_FLAG,
  input wire logic PACKET_END_FLAG,
  input wire logic PACKET_ERROR_FLAG,
  input wire logic LINE_WRITE_STROBE,
  input wire logic [PORT_W-1:0] LOGICAL_PORT_NUMBER,
  input wire logic [PART_W-1:0] PARTITION_SELECT,
  input wire logic LINE_TERMINATE_PULSE,
  input wire logic BUFFER_SERVICE_DISABLE,
  output logic PARTITION_FULL_FLAG,
  output logic SERVICE_IDLE
);
  tlbw_pins_t pin_raw;
  tlbw_pins_t pins;
  tlbw_regs_if rif ();
  logic wclk_prev_q;
  logic svc_idle_q;
  logic full_q;
  logic [PART_W-1:0] part_hist_q;
  logic sop_q [LINE_N];
  logic eop_q [LINE_N];
  logic err_q [LINE_N];
  logic [BE_W-1:0] be_q [LINE_N];
  logic [PORT_W-1:0] port_q [LINE_N];
  wire [CNT_W-1:0] cnt [PART_N];
  wire [WSEL_W-1:0] wcnt [PART_N];
  wire [LPTR_W-1:0] wptr [PART_N];
  wire [LPTR_W-1:0] rptr [PART_N];
  wire [PART_N*CNT_W-1:0] cnt_vec;
  wire [PART_N*WSEL_W-1:0] wcnt_vec;
  wire [PART_N*LPTR_W-1:0] wptr_vec;
  wire [PART_N*LPTR_W-1:0] rptr_vec;
  wire [WORDS_PER_LINE-1:0][DATA_W-1:0] head_w;

  assign pin_raw.wclk = WRITE_SIDE_CLOCK;
  assign pin_raw.data = WRITE_WORD_BUS;
  assign pin_raw.be = BYTE_VALID_MASK;
  assign pin_raw.sop = PACKET_START_FLAG;
  assign pin_raw.eop = PACKET_END_FLAG;
  assign pin_raw.err = PACKET_ERROR_FLAG;
  assign pin_raw.we = LINE_WRITE_STROBE;
  assign pin_raw.port = LOGICAL_PORT_NUMBER;
  assign pin_raw.part = PARTITION_SELECT;
  assign pin_raw.term = LINE_TERMINATE_PULSE;
  assign pin_raw.dis = BUFFER_SERVICE_DISABLE;

  // All write-side pins cross into CLK together, so they stay aligned.
  tlbw_sync #(
    .W($bits(tlbw_pins_t))
  ) u_pin_sync (
    .clk(CLK),
    .rst(RST),
    .d(pin_raw),
    .sync_q(pins)
  );

  tlbw_apb u_apb (
    .clk(CLK),
    .rst(RST),
    .paddr(PADDR),
    .psel(PSEL),
    .penable(PENABLE),
    .pwrite(PWRITE),
    .pwdata(PWDATA),
    .prdata(PRDATA),
    .pready(PREADY),
    .pslverr(PSLVERR),
    .rif(rif)
  );

  // Write-clock rising edge, seen in the CLK domain.
  wire wr_rise = pins.wclk & ~wclk_prev_q;
  wire [CNT_W-1:0] cnt_sel = cnt[pins.part];
  wire [WSEL_W-1:0] wcnt_sel = wcnt[pins.part];
  wire [LPTR_W-1:0] wptr_sel = wptr[pins.part];
  wire room = cnt_sel != LINES_MAX;
  wire wr_take = wr_rise & pins.we & room;
  wire wr_keep = wr_take & (pins.be != BE_NONE);
  wire line_done = wr_keep & (pins.eop | (wcnt_sel == LAST_WORD));
  wire term_hit = wr_rise & pins.term & room;
  wire adv = line_done | term_hit;
  wire [CNT_W-1:0] rd_cnt = cnt[rif.read_sel];
  wire pop_ok = rif.pop & ~pins.dis & (rd_cnt != '0);
  wire [LINE_IDX_W-1:0] wr_line = {pins.part, wptr_sel};
  wire [WORD_IDX_W-1:0] wr_word_idx = {wr_line, wcnt_sel};
  wire [LINE_IDX_W-1:0] rd_line = {rif.read_sel, rptr[rif.read_sel]};
  wire [CNT_W-1:0] cnt_hist = cnt[part_hist_q];
  wire [WSEL_W-1:0] wcnt_hist = wcnt[part_hist_q];
  wire [LPTR_W-1:0] wptr_hist = wptr[part_hist_q];

  // Per-partition pointers; pointers wrap since the line count is 2**n.
  for (genvar p = 0; p < PART_N; p++)
  begin : g_part
    logic [CNT_W-1:0] cnt_q;
    logic [WSEL_W-1:0] wcnt_q;
    logic [LPTR_W-1:0] wptr_q;
    logic [LPTR_W-1:0] rptr_q;
    wire hit_w = pins.part == PART_W'(p);
    wire adv_p = adv & hit_w;
    wire acc_p = wr_keep & hit_w;
    wire pop_p = pop_ok & (rif.read_sel == PART_W'(p));
    assign cnt[p] = cnt_q;
    assign wcnt[p] = wcnt_q;
    assign wptr[p] = wptr_q;
    assign rptr[p] = rptr_q;
    assign cnt_vec[p*CNT_W +: CNT_W] = cnt_q;
    assign wcnt_vec[p*WSEL_W +: WSEL_W] = wcnt_q;
    assign wptr_vec[p*LPTR_W +: LPTR_W] = wptr_q;
    assign rptr_vec[p*LPTR_W +: LPTR_W] = rptr_q;
    always_ff @(posedge CLK)
    begin
      if (RST)
      begin
        cnt_q <= '0;
        wcnt_q <= '0;
        wptr_q <= '0;
        rptr_q <= '0;
      end
      else
      begin
        cnt_q <= cnt_q + CNT_W'(adv_p) - CNT_W'(pop_p);
        wcnt_q <= adv_p ? '0 : wcnt_q + WSEL_W'(acc_p);
        wptr_q <= wptr_q + LPTR_W'(adv_p);
        rptr_q <= rptr_q + LPTR_W'(pop_p);
      end
    end
  end

  // One memory bank per byte lane, written only under its mask bit.
  for (genvar b = 0; b < BE_W; b++)
  begin : g_lane
    logic [BYTE_W-1:0] mem_q [WORD_N];
    wire lane_we = wr_keep & pins.be[b];
    always_ff @(posedge CLK)
    begin
      if (lane_we)
      begin
        mem_q[wr_word_idx] <= pins.data[b*BYTE_W +: BYTE_W];
      end
    end
    for (genvar w = 0; w < WORDS_PER_LINE; w++)
    begin : g_word
      assign head_w[w][b*BYTE_W +: BYTE_W] =
        mem_q[{rd_line, WSEL_W'(w)}];
    end
    a_lane_store: assert property (@(posedge CLK) disable iff (RST)
      lane_we |=> mem_q[$past(wr_word_idx)] ==
        $past(pins.data[b*BYTE_W +: BYTE_W]))
      else $error("Enabled byte lane was not stored.");
  end

  // Line qualifiers; the mask of the last word tells the valid bytes.
  always_ff @(posedge CLK)
  begin
    if (wr_keep)
    begin
      port_q[wr_line] <= pins.port;
      eop_q[wr_line] <= pins.eop;
      err_q[wr_line] <= pins.err;
      be_q[wr_line] <= pins.be;
      if (wcnt_sel == '0)
      begin
        sop_q[wr_line] <= pins.sop;
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      wclk_prev_q <= 1'b0;
      svc_idle_q <= 1'b0;
      full_q <= 1'b0;
      part_hist_q <= '0;
    end
    else
    begin
      wclk_prev_q <= pins.wclk;
      svc_idle_q <= pins.dis;
      full_q <= cnt_sel >= rif.fill_level;
      part_hist_q <= pins.part;
    end
  end

  assign PARTITION_FULL_FLAG = full_q;
  assign SERVICE_IDLE = svc_idle_q;
  assign rif.service_off = svc_idle_q;
  assign rif.level = rd_cnt;
  assign rif.head_sop = sop_q[rd_line];
  assign rif.head_eop = eop_q[rd_line];
  assign rif.head_err = err_q[rd_line];
  assign rif.head_be = be_q[rd_line];
  assign rif.head_port = port_q[rd_line];
  assign rif.head_line = head_w;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  sequence s_empty_write;
    wr_rise && pins.we && pins.be == BE_NONE && !pins.term;
  endsequence

  sequence s_line_end;
    line_done && !pop_ok;
  endsequence

  sequence s_quiet;
    !(wr_rise && (pins.we || pins.term)) && !pop_ok;
  endsequence

  sequence s_disabled;
    pins.dis [*2];
  endsequence

  a_empty_drop: assert property (
    s_empty_write |=> $stable(wcnt_vec) && $stable(wptr_vec))
    else $error("Empty-mask write changed the buffer.");

  a_eop_advance: assert property (
    line_done && pins.eop |=> wcnt_hist == '0 &&
      wptr_hist == LPTR_W'($past(wptr_sel) + 1'b1))
    else $error("Packet end did not move to the next line.");

  a_line_commit: assert property (
    s_line_end |=> cnt_hist == CNT_W'($past(cnt_sel) + 1'b1))
    else $error("Finished line not counted.");

  a_word_store: assert property (
    wr_keep && !adv |=> wcnt_hist == WSEL_W'($past(wcnt_sel) + 1'b1))
    else $error("Strobed word did not advance the word slot.");

  a_term_advance: assert property (
    term_hit |=> wcnt_hist == '0 &&
      wptr_hist == LPTR_W'($past(wptr_sel) + 1'b1))
    else $error("Line terminate did not move the pointer.");

  a_quiet_hold: assert property (
    s_quiet |=> $stable(wcnt_vec) && $stable(cnt_vec) &&
      $stable(wptr_vec) && $stable(rptr_vec))
    else $error("Pointers moved without a strobe.");

  a_service_hold: assert property (
    s_disabled |=> $stable(rptr_vec) && SERVICE_IDLE)
    else $error("Disabled buffer was drained.");

  a_full_track: assert property (
    1'b1 |=> PARTITION_FULL_FLAG == $past(cnt_sel >= rif.fill_level))
    else $error("Full flag disagrees with the fill level.");

  a_no_overfill: assert property (
    wr_rise && pins.we && !room && !pins.term && !pop_ok |=>
      $stable(wcnt_vec) && $stable(wptr_vec) && cnt_hist == LINES_MAX)
    else $error("Write accepted into a full partition.");
endmodule : tlbw_top

/* File: verification/tlbw_top_tb.sv */
// Self-checking bench of the transmit line buffer write port.
`timescale 1ns/100ps
module tlbw_top_tb
  import tlbw_pkg::*;
;
  logic clk;
  logic rst;
  logic [ADDR_W-1:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic full;
  logic idle;
  logic [DATA_W-1:0] rd;
  logic er;
  int n_errors;
  int compares;
  wire tlbw_pins_t w;

  tlbw_writer tlbw_writer_i (.clk(clk), .wclk(w.wclk), .data(w.data),
    .be(w.be), .sop(w.sop), .eop(w.eop), .err(w.err), .we(w.we),
    .port(w.port), .part(w.part), .term(w.term), .dis(w.dis));

  tlbw_top tlbw_top_i (.CLK(clk), .RST(rst), .PADDR(paddr), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .WRITE_SIDE_CLOCK(w.wclk),
    .WRITE_WORD_BUS(w.data), .BYTE_VALID_MASK(w.be),
    .PACKET_START_FLAG(w.sop), .PACKET_END_FLAG(w.eop),
    .PACKET_ERROR_FLAG(w.err), .LINE_WRITE_STROBE(w.we),
    .LOGICAL_PORT_NUMBER(w.port), .PARTITION_SELECT(w.part),
    .LINE_TERMINATE_PULSE(w.term), .BUFFER_SERVICE_DISABLE(w.dis),
    .PARTITION_FULL_FLAG(full), .SERVICE_IDLE(idle));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic give_verdict();
    if (n_errors == 0 && compares > 0)
    begin
      $display("== PASSED ==");
    end
    else
    begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [DATA_W-1:0] got,
    input logic [DATA_W-1:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h not %h", $time, got, exp);
    end
  endtask : chk

  // Setup cycle, then access phase until pready is seen high.
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(32'(n), 32'h1);
  endtask : apb

  task automatic look(input logic [PART_W-1:0] p);
    apb(1'b1, OFS_SEL, 32'(p));
    apb(1'b0, OFS_STATUS, 32'h0);
  endtask : look

  task automatic t_reset();
    apb(1'b0, OFS_FILL, 32'h0);
    chk(rd, 32'(FILL_RST));
    look(3'h0);
    chk(32'({rd[6:4], rd[0]}), 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({rd[31:1], er}, 32'h1);
    chk(32'({full, idle}), 32'h0);
  endtask : t_reset

  task automatic t_line();
    logic [DATA_W-1:0] d [4];
    d = '{32'h11223344, 32'h55667788, 32'h99AABBCC, 32'hDDEEFF00};
    for (int i = 0; i < 4; i++)
    begin
      tlbw_writer_i.put(d[i], BE_ALL, {i == 0, 3'h0}, 1'b1, 3'h2);
    end
    look(3'h2);
    chk(32'({rd[6:4], rd[8]}), 32'h3);
    chk(32'(rd[23:12]), 32'h58F);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, OFS_DATA0 + 8'(4 * i), 32'h0);
      chk(rd, d[i]);
    end
    look(3'h1);
    chk(32'(rd[6:4]), 32'h0);
    apb(1'b1, OFS_POP, 32'h0);
    look(3'h2);
    chk(32'(rd[6:4]), 32'h1);
    apb(1'b1, OFS_POP, 32'h0);
    look(3'h2);
    chk(32'(rd[6:4]), 32'h0);
  endtask : t_line

  task automatic t_short();
    tlbw_writer_i.put(32'hA1B2C3D4, BE_ALL, 4'h8, 1'b1, 3'h1);
    tlbw_writer_i.put(32'h0BADF00D, BE_NONE, 4'h4, 1'b1, 3'h1);
    tlbw_writer_i.put(32'h0BADF00D, BE_ALL, 4'h4, 1'b0, 3'h1);
    look(3'h1);
    chk(32'(rd[6:4]), 32'h0);
    tlbw_writer_i.put(32'hE5F6A7B8, 4'hE, 4'h6, 1'b1, 3'h1);
    tlbw_writer_i.put(32'h12345678, 4'h8, 4'hC, 1'b1, 3'h1);
    look(3'h1);
    chk(32'(rd[6:4]), 32'h2);
    chk(32'(rd[15:8]), 32'hE7);
    apb(1'b0, OFS_DATA0 + 8'h04, 32'h0);
    chk(rd & 32'hFFFFFF00, 32'hE5F6A700);
    apb(1'b1, OFS_POP, 32'h0);
    look(3'h1);
    chk(32'(rd[15:12]), 32'h8);
    apb(1'b0, OFS_DATA0, 32'h0);
    chk(rd & 32'hFF000000, 32'h12000000);
    apb(1'b1, OFS_POP, 32'h0);
  endtask : t_short

  task automatic t_term();
    tlbw_writer_i.put(32'h0, BE_NONE, 4'h1, 1'b0, 3'h3);
    look(3'h3);
    chk(32'(rd[6:4]), 32'h1);
    for (int i = 0; i < 3; i++)
    begin
      tlbw_writer_i.put(32'h0, BE_NONE, 4'h1, 1'b0, 3'h3);
    end
    tlbw_writer_i.put(32'hC0FFEE00, BE_ALL, 4'h0, 1'b1, 3'h3);
    look(3'h3);
    chk(32'(rd[6:4]), 32'h4);
    apb(1'b1, OFS_POP, 32'h0);
  endtask : t_term

  task automatic t_full();
    apb(1'b1, OFS_FILL, 32'h2);
    tlbw_writer_i.set_dis(1'b1, 3'h4);
    chk(32'(idle), 32'h1);
    tlbw_writer_i.put(32'h0, BE_NONE, 4'h1, 1'b0, 3'h4);
    chk(32'(full), 32'h0);
    tlbw_writer_i.put(32'h0, BE_NONE, 4'h1, 1'b0, 3'h4);
    chk(32'(full), 32'h1);
    apb(1'b1, OFS_SEL, 32'h4);
    apb(1'b1, OFS_POP, 32'h0);
    look(3'h4);
    chk(32'({rd[6:4], rd[0]}), 32'h5);
    tlbw_writer_i.put(32'h0, BE_NONE, 4'h0, 1'b0, 3'h5);
    chk(32'(full), 32'h0);
    tlbw_writer_i.set_dis(1'b0, 3'h4);
    chk(32'({full, idle}), 32'h2);
    apb(1'b1, OFS_POP, 32'h0);
    look(3'h4);
    chk(32'(rd[6:4]), 32'h1);
    apb(1'b1, OFS_FILL, 32'h4);
  endtask : t_full

  initial
  begin
    #200000;
    n_errors++;
    give_verdict();
  end

  initial
  begin
    n_errors = 0;
    compares = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_line();
    t_short();
    t_term();
    t_full();
    give_verdict();
  end
endmodule : tlbw_top_tb

/* File: verification/tlbw_writer.sv */
// Model of the user logic that writes words into the buffer.
`timescale 1ns/100ps
module tlbw_writer
  import tlbw_pkg::*;
(
  input wire logic clk,
  output logic wclk,
  output logic [DATA_W-1:0] data,
  output logic [BE_W-1:0] be,
  output logic sop,
  output logic eop,
  output logic err,
  output logic we,
  output logic [PORT_W-1:0] port,
  output logic [PART_W-1:0] part,
  output logic term,
  output logic dis
);
  initial
  begin
    wclk = 1'b0;
    data = 32'h0;
    be = 4'h0;
    {sop, eop, err, term} = 4'h0;
    we = 1'b0;
    port = 8'h00;
    part = 3'h0;
    dis = 1'b0;
  end

  // One 400 ns write clock period per transfer; it stands still between.
  task automatic put(input logic [DATA_W-1:0] d, input logic [BE_W-1:0] m,
    input logic [3:0] f, input logic w, input logic [PART_W-1:0] p);
    @(posedge clk);
    data <= d;
    be <= m;
    {sop, eop, err, term} <= f;
    we <= w;
    port <= 8'h5A ^ {5'h00, p};
    part <= p;
    repeat (2) @(posedge clk);
    wclk <= 1'b1;
    repeat (4) @(posedge clk);
    wclk <= 1'b0;
    we <= 1'b0;
    data <= ~d;
    {sop, eop, err, term} <= 4'h0;
    @(posedge clk);
  endtask : put

  // The disable level is sampled at every CLK edge, not at a write clock rise; the put that follows gives it time.
  task automatic set_dis(input logic v, input logic [PART_W-1:0] p);
    @(posedge clk);
    dis <= v;
    put(32'h0, 4'h0, 4'h0, 1'b0, p);
  endtask : set_dis
endmodule : tlbw_writer
